// file: tbs_pkg.sv
// shared constants, register map and types of the tape byte serdes
package tbs_pkg;
    localparam int TBS_DATA_W = 8;
    localparam int TBS_APB_DW = 32;
    localparam int TBS_ADDR_W = 8;
    localparam int TBS_SYNC_STAGES = 2;
    localparam int TBS_LINK_W = 4;
    localparam int TBS_CTRL_W = 2;
    localparam int TBS_STAT_W = 6;

    // register byte offsets
    localparam logic [TBS_ADDR_W-1:0] TBS_OFF_CTRL = 8'h00;
    localparam logic [TBS_ADDR_W-1:0] TBS_OFF_WDATA = 8'h04;
    localparam logic [TBS_ADDR_W-1:0] TBS_OFF_FILL = 8'h08;
    localparam logic [TBS_ADDR_W-1:0] TBS_OFF_SYNC = 8'h0C;
    localparam logic [TBS_ADDR_W-1:0] TBS_OFF_RDATA = 8'h10;
    localparam logic [TBS_ADDR_W-1:0] TBS_OFF_RCLR = 8'h14;
    localparam logic [TBS_ADDR_W-1:0] TBS_OFF_STATUS = 8'h18;

    // control fields and reset values
    localparam int TBS_CTRL_GATE_BIT = 0;
    localparam int TBS_CTRL_WEN_BIT = 1;
    localparam logic [TBS_CTRL_W-1:0] TBS_CTRL_RST = 2'h1;
    localparam logic [TBS_DATA_W-1:0] TBS_FILL_RST = 8'h00;
    localparam logic [TBS_DATA_W-1:0] TBS_SYNC_RST = 8'h00;
    localparam logic [TBS_DATA_W-1:0] TBS_BYTE_ZERO = 8'h00;
    localparam logic [2:0] TBS_BIT_FIRST = 3'h0;
    localparam logic [2:0] TBS_BIT_LAST = 3'h7;
    localparam logic [2:0] TBS_BIT_STEP = 3'h1;

    // rx mode of the read path
    typedef enum logic [1:0] {
        TBS_RX_IDLE = 2'b00,
        TBS_RX_SEARCH = 2'b01,
        TBS_RX_BYTE = 2'b10
    } tbs_rx_mode_type;

    // lsb-first shift: new bit enters at the top
    function automatic logic [TBS_DATA_W-1:0] tbs_shift_right(input logic [TBS_DATA_W-1:0] val, input logic bit_in);
        tbs_shift_right = {bit_in, val[TBS_DATA_W-1:1]};
    endfunction : tbs_shift_right
endpackage : tbs_pkg

// file: tbs_sync.sv
// two-stage synchroniser for inputs from outside the pclk domain
`timescale 1ns/100ps
module tbs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule : tbs_sync

// file: tbs_edge.sv
// edge finder for a level already in the pclk domain
`timescale 1ns/100ps
module tbs_edge #(
    parameter logic INIT = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    output logic rise,
    output logic fall
);
    logic prev_ff;

    // init lets a level that idles high not fake a rise at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_ff <= INIT;
        end else begin
            prev_ff <= level;
        end
    end

    assign rise = level & ~prev_ff;
    assign fall = ~level & prev_ff;
endmodule : tbs_edge

// file: tbs_byte_serdes_sync.sv
// tape byte serdes: apb registers, lsb-first write serializer with fill, sync-hunting read deserializer
`timescale 1ns/100ps
module tbs_byte_serdes_sync import tbs_pkg::*; #(
    parameter int ADDR_W = TBS_ADDR_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TBS_APB_DW-1:0] pwdata,
    output logic [TBS_APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic read_bit_clock,
    input wire logic serial_read_in,
    input wire logic read_bus_enable,
    input wire logic write_bit_clock,
    output logic serial_write_out,
    output logic tape_write_enable,
    output logic [TBS_DATA_W-1:0] read_data_out,
    output logic read_data_oe,
    output logic write_byte_request,
    output logic write_underrun_flag,
    output logic read_byte_request,
    output logic read_lost_flag,
    output logic sync_detected
);
    localparam int RSV_CTRL = TBS_APB_DW - TBS_CTRL_W;
    localparam int RSV_DATA = TBS_APB_DW - TBS_DATA_W;
    localparam int RSV_STAT = TBS_APB_DW - TBS_STAT_W;
    // link pins, all sampled through two flops
    logic [TBS_LINK_W-1:0] link_s;
    logic rck_s;
    logic rdin_s;
    logic wck_s;
    logic rbe_s;
    tbs_sync #(.WIDTH(TBS_LINK_W)) u_link_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({read_bit_clock, serial_read_in, write_bit_clock, read_bus_enable}),
        .q(link_s)
    );
    assign {rck_s, rdin_s, wck_s, rbe_s} = link_s;
    // apb slave state and registers
    logic pready_ff;
    logic pslverr_ff;
    logic [TBS_APB_DW-1:0] prdata_ff;
    logic [TBS_CTRL_W-1:0] ctrl_ff;
    logic [TBS_DATA_W-1:0] fill_ff;
    logic [TBS_DATA_W-1:0] sync_ff;
    logic [TBS_DATA_W-1:0] wdata_hold_ff;
    // write path state
    logic w_running_ff;
    logic [2:0] wcnt_ff;
    logic [TBS_DATA_W-1:0] wsr_ff;
    logic hold_full_ff;
    logic wreq_ff;
    logic wund_ff;
    logic wout_ff;
    logic wen_ff;
    // read path state
    tbs_rx_mode_type rmode_ff;
    tbs_rx_mode_type nxt_rmode;
    logic [2:0] rcnt_ff;
    logic [TBS_DATA_W-1:0] rsr_ff;
    logic [TBS_DATA_W-1:0] rhold_ff;
    logic rpend_ff;
    logic rreq_ff;
    logic rlost_ff;
    logic sdet_ff;
    logic [TBS_DATA_W-1:0] rdo_ff;
    logic roe_ff;
    // edges of the two bit clocks and of the read gate bit; one edge per bit clock is used
    logic rck_fall;
    logic wck_rise;
    logic gate_rise;
    logic gate_fall;
    tbs_edge #(.INIT(1'b0)) u_rck_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(rck_s),
        .rise(),
        .fall(rck_fall)
    );
    tbs_edge #(.INIT(1'b0)) u_wck_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(wck_s),
        .rise(wck_rise),
        .fall()
    );
    // gate idles high, so a reset start must not look like a rise
    tbs_edge #(.INIT(1'b1)) u_gate_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level(ctrl_ff[TBS_CTRL_GATE_BIT]),
        .rise(gate_rise),
        .fall(gate_fall)
    );

    // apb decode; access completes in the cycle after setup
    wire setup_ph = psel & ~penable;
    wire wr_acc = psel & penable & pwrite & pready_ff;
    wire hit_ctrl = (paddr == TBS_OFF_CTRL);
    wire hit_wdata = (paddr == TBS_OFF_WDATA);
    wire hit_fill = (paddr == TBS_OFF_FILL);
    wire hit_sync = (paddr == TBS_OFF_SYNC);
    wire hit_rdata = (paddr == TBS_OFF_RDATA);
    wire hit_rclr = (paddr == TBS_OFF_RCLR);
    wire hit_status = (paddr == TBS_OFF_STATUS);
    wire mapped = hit_ctrl | hit_wdata | hit_fill | hit_sync | hit_rdata | hit_rclr | hit_status;
    wire wdata_strobe = wr_acc & hit_wdata;
    wire rclr_pulse = wr_acc & hit_rclr;
    wire [TBS_STAT_W-1:0] status_w = {(rmode_ff == TBS_RX_BYTE), sdet_ff, rlost_ff, rreq_ff, wund_ff, wreq_ff};
    wire [TBS_APB_DW-1:0] rd_mux =
        hit_ctrl ? {{RSV_CTRL{1'b0}}, ctrl_ff} :
        hit_fill ? {{RSV_DATA{1'b0}}, fill_ff} :
        hit_sync ? {{RSV_DATA{1'b0}}, sync_ff} :
        hit_rdata ? {{RSV_DATA{1'b0}}, rhold_ff} :
        hit_status ? {{RSV_STAT{1'b0}}, status_w} : '0;

    // read data captured at setup so prdata is a flop in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= setup_ph;
            pslverr_ff <= setup_ph & ~mapped;
            if (setup_ph) begin
                prdata_ff <= pwrite ? '0 : rd_mux;
            end
        end
    end

    // software-written registers, each loaded by its own address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= TBS_CTRL_RST;
            fill_ff <= TBS_FILL_RST;
            sync_ff <= TBS_SYNC_RST;
            wdata_hold_ff <= TBS_BYTE_ZERO;
        end else begin
            if (wr_acc & hit_ctrl) ctrl_ff <= pwdata[TBS_CTRL_W-1:0];
            if (wr_acc & hit_fill) fill_ff <= pwdata[TBS_DATA_W-1:0];
            if (wr_acc & hit_sync) sync_ff <= pwdata[TBS_DATA_W-1:0];
            if (wdata_strobe) wdata_hold_ff <= pwdata[TBS_DATA_W-1:0];
        end
    end

    // write serializer decode; runs only while the drive write enable is set
    wire wen = ctrl_ff[TBS_CTRL_WEN_BIT];
    wire w_last = (wcnt_ff == TBS_BIT_LAST);
    wire w_start = wck_rise & wen & ~w_running_ff & hold_full_ff;
    wire w_reload = wck_rise & wen & w_running_ff & w_last;
    wire w_shift = wck_rise & wen & w_running_ff & ~w_last;
    wire w_take = w_start | (w_reload & hold_full_ff);
    wire w_fill = w_reload & ~hold_full_ff;
    wire [TBS_DATA_W-1:0] nxt_wsr =
        w_take ? wdata_hold_ff :
        w_fill ? fill_ff :
        w_shift ? tbs_shift_right(wsr_ff, 1'b0) : wsr_ff;
    wire nxt_wout = wen & (w_running_ff | w_start) & nxt_wsr[0];

    // shifter, bit count and serial pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_running_ff <= 1'b0;
            wcnt_ff <= TBS_BIT_FIRST;
            wsr_ff <= TBS_BYTE_ZERO;
            wout_ff <= 1'b0;
            wen_ff <= 1'b0;
        end else begin
            w_running_ff <= wen & (w_running_ff | w_start);
            wsr_ff <= nxt_wsr;
            wout_ff <= nxt_wout;
            wen_ff <= wen;
            if (~wen | w_start | w_reload) begin
                wcnt_ff <= TBS_BIT_FIRST;
            end else if (w_shift) begin
                wcnt_ff <= wcnt_ff + TBS_BIT_STEP;
            end
        end
    end

    // holding flags; a strobe in the transfer cycle still counts as a fresh byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_full_ff <= 1'b0;
            wreq_ff <= 1'b0;
            wund_ff <= 1'b0;
        end else begin
            if (wdata_strobe) hold_full_ff <= 1'b1;
            else if (w_take) hold_full_ff <= 1'b0;
            if (wdata_strobe) wreq_ff <= 1'b0;
            else if (w_take) wreq_ff <= 1'b1;
            if (w_fill) wund_ff <= 1'b1;
            else if (wdata_strobe) wund_ff <= 1'b0;
        end
    end

    // read path decode; sampling on the falling read clock
    wire [TBS_DATA_W-1:0] rsr_next = tbs_shift_right(rsr_ff, rdin_s);
    wire srch_match = rck_fall & (rmode_ff == TBS_RX_SEARCH) & (rsr_next == sync_ff);
    wire byte_done = rck_fall & (rmode_ff == TBS_RX_BYTE) & (rcnt_ff == TBS_BIT_LAST);
    wire r_xfer = srch_match | byte_done;
    wire r_req_set = rck_fall & rpend_ff;

    // rx mode: gate fall hunts, match frames, gate rise stops
    always_comb begin
        nxt_rmode = rmode_ff;
        unique case (rmode_ff)
            TBS_RX_IDLE: begin
                if (gate_fall) nxt_rmode = TBS_RX_SEARCH;
            end
            TBS_RX_SEARCH: begin
                if (gate_rise) nxt_rmode = TBS_RX_IDLE;
                else if (srch_match) nxt_rmode = TBS_RX_BYTE;
            end
            TBS_RX_BYTE: begin
                if (gate_rise) nxt_rmode = TBS_RX_IDLE;
            end
            default: nxt_rmode = TBS_RX_IDLE;
        endcase
    end

    // input shifter runs on every read clock fall, framing only counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rmode_ff <= TBS_RX_IDLE;
            rsr_ff <= TBS_BYTE_ZERO;
            rcnt_ff <= TBS_BIT_FIRST;
            rhold_ff <= TBS_BYTE_ZERO;
        end else begin
            rmode_ff <= nxt_rmode;
            if (rck_fall) rsr_ff <= rsr_next;
            if (gate_fall | srch_match) begin
                rcnt_ff <= TBS_BIT_FIRST;
            end else if (rck_fall & (rmode_ff == TBS_RX_BYTE)) begin
                rcnt_ff <= rcnt_ff + TBS_BIT_STEP;
            end
            if (r_xfer) rhold_ff <= rsr_next;
        end
    end

    // request, lost and sync flags; hardware set wins over clear for request and lost, a gate change clear wins over a sync set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpend_ff <= 1'b0;
            rreq_ff <= 1'b0;
            rlost_ff <= 1'b0;
            sdet_ff <= 1'b0;
        end else begin
            if (r_xfer) rpend_ff <= 1'b1;
            else if (rck_fall) rpend_ff <= 1'b0;
            if (r_req_set) rreq_ff <= 1'b1;
            else if (rclr_pulse) rreq_ff <= 1'b0;
            if (r_xfer & (rreq_ff | rpend_ff)) rlost_ff <= 1'b1;
            else if (gate_fall) rlost_ff <= 1'b0;
            if (gate_fall | gate_rise) sdet_ff <= 1'b0;
            else if (srch_match) sdet_ff <= 1'b1;
            else if (byte_done) sdet_ff <= (rsr_next == sync_ff);
        end
    end

    // parallel read bus; oe low stands for the released bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdo_ff <= TBS_BYTE_ZERO;
            roe_ff <= 1'b0;
        end else begin
            rdo_ff <= rbe_s ? rhold_ff : TBS_BYTE_ZERO;
            roe_ff <= rbe_s;
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign serial_write_out = wout_ff;
    assign tape_write_enable = wen_ff;
    assign read_data_out = rdo_ff;
    assign read_data_oe = roe_ff;
    assign write_byte_request = wreq_ff;
    assign write_underrun_flag = wund_ff;
    assign read_byte_request = rreq_ff;
    assign read_lost_flag = rlost_ff;
    assign sync_detected = sdet_ff;
    // checks next to the logic; covers mark the main scenarios
    property p_wreq_on_take;
        @(posedge pclk) disable iff (!presetn) (w_take & ~wdata_strobe) |=> write_byte_request;
    endproperty
    a_wreq_on_take: assert property (p_wreq_on_take) else $error("write request not raised on transfer");
    property p_fill_load;
        @(posedge pclk) disable iff (!presetn) w_fill |=> (wsr_ff == $past(fill_ff)) & write_underrun_flag;
    endproperty
    a_fill_load: assert property (p_fill_load) else $error("fill byte or underrun missing");
    property p_und_clear;
        @(posedge pclk) disable iff (!presetn) (wdata_strobe & ~w_fill) |=> ~write_underrun_flag & ~write_byte_request;
    endproperty
    a_und_clear: assert property (p_und_clear) else $error("strobe did not clear flags");
    property p_lsb_shift;
        @(posedge pclk) disable iff (!presetn) w_shift |=>
            (wsr_ff == {1'b0, $past(wsr_ff[TBS_DATA_W-1:1])}) & (serial_write_out == wsr_ff[0]);
    endproperty
    a_lsb_shift: assert property (p_lsb_shift) else $error("serial out not lsb first");
    property p_reload_count;
        @(posedge pclk) disable iff (!presetn) w_reload |=> (wcnt_ff == TBS_BIT_FIRST) & ((wsr_ff == $past(wdata_hold_ff)) | (wsr_ff == $past(fill_ff)));
    endproperty
    a_reload_count: assert property (p_reload_count) else $error("shifter reload after eighth bit wrong");
    property p_search_start;
        @(posedge pclk) disable iff (!presetn) (gate_fall & (rmode_ff == TBS_RX_IDLE)) |=> (rmode_ff == TBS_RX_SEARCH) & ~sync_detected;
    endproperty
    a_search_start: assert property (p_search_start) else $error("gate fall did not start search");
    property p_sync_found;
        @(posedge pclk) disable iff (!presetn) (srch_match & ~gate_rise) |=> sync_detected & (rmode_ff == TBS_RX_BYTE) & (rhold_ff == $past(rsr_next));
    endproperty
    a_sync_found: assert property (p_sync_found) else $error("sync match not framed");
    property p_req_after_fall;
        @(posedge pclk) disable iff (!presetn) (r_xfer & ~rpend_ff & ~read_byte_request) |=> rpend_ff & ~read_byte_request;
    endproperty
    a_req_after_fall: assert property (p_req_after_fall) else $error("read request raised before next clock fall");
    property p_req_clear;
        @(posedge pclk) disable iff (!presetn) (rclr_pulse & ~r_req_set) |=> ~read_byte_request;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request clear ignored");
    property p_lost;
        @(posedge pclk) disable iff (!presetn) (r_xfer & read_byte_request) |=> read_lost_flag;
    endproperty
    a_lost: assert property (p_lost) else $error("lost byte not flagged");
    property p_bus_drive;
        @(posedge pclk) disable iff (!presetn) $rose(rbe_s) |=> read_data_oe & (read_data_out == $past(rhold_ff));
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("read bus not driven");
    c_underrun: cover property (@(posedge pclk) disable iff (!presetn) w_fill ##[1:1000] wdata_strobe);
    c_sync: cover property (@(posedge pclk) disable iff (!presetn) srch_match);
    c_lost: cover property (@(posedge pclk) disable iff (!presetn) $rose(read_lost_flag));
    c_rww: cover property (@(posedge pclk) disable iff (!presetn) byte_done & w_running_ff);
endmodule : tbs_byte_serdes_sync

// file: tbs_tape_model.sv
// tape drive stand-in: bit clocks, serial read stream and write capture
`timescale 1ns/100ps
module tbs_tape_model (
    input wire logic wclk_en,
    input wire logic rclk_en,
    input wire logic [15:0] rd_word,
    input wire logic serial_write_out,
    output logic write_bit_clock,
    output logic read_bit_clock,
    output logic serial_read_in,
    output logic [7:0] wr_byte,
    output int wr_bits
);
    logic [3:0] ri;

    // write clock runs only inside a frame; bits are taken mid-cell on the fall
    initial begin
        write_bit_clock = 1'h0;
        wr_byte = 8'h00;
        wr_bits = 0;
        forever begin
            #62.5;
            if (wclk_en) begin
                write_bit_clock = ~write_bit_clock;
                if (!write_bit_clock) begin
                    wr_byte = {serial_write_out, wr_byte[7:1]}; // lsb arrives first
                    wr_bits++;
                end
            end
        end
    end

    // read data changes on the rise so the falling edge sees a settled bit
    initial begin
        read_bit_clock = 1'h0;
        serial_read_in = 1'h0;
        ri = 4'h0;
        forever begin
            #62.5;
            if (rclk_en) begin
                read_bit_clock = ~read_bit_clock;
                if (read_bit_clock) begin
                    serial_read_in = rd_word[ri];
                    ri++;
                end
            end else begin
                serial_read_in = ~serial_read_in; // idle line never holds a stale bit
            end
        end
    end
endmodule : tbs_tape_model

// file: tbs_byte_serdes_sync_tb.sv
// self-checking bench of the tape byte serdes
`timescale 1ns/100ps
module tbs_byte_serdes_sync_tb import tbs_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, d, d2, d3, f, rdo, wr_byte;
    logic [31:0] pwdata, prdata, q;
    logic rbe, wclk_en, rclk_en, wbc, rbc, sri, swo, twe, roe, wreq, wund, rreq, rlost, sdet;
    logic [15:0] rd_word;
    int wr_bits, num_errors, n_compared;
    logic [7:0] ra[5] = '{TBS_OFF_CTRL, TBS_OFF_FILL, TBS_OFF_SYNC, TBS_OFF_RDATA, TBS_OFF_STATUS};
    logic [31:0] rv[5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

    tbs_byte_serdes_sync i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .read_bit_clock(rbc), .serial_read_in(sri), .read_bus_enable(rbe),
        .write_bit_clock(wbc), .serial_write_out(swo), .tape_write_enable(twe), .read_data_out(rdo),
        .read_data_oe(roe), .write_byte_request(wreq), .write_underrun_flag(wund),
        .read_byte_request(rreq), .read_lost_flag(rlost), .sync_detected(sdet));
    tbs_tape_model i_tape (.wclk_en(wclk_en), .rclk_en(rclk_en), .rd_word(rd_word),
        .serial_write_out(swo), .write_bit_clock(wbc), .read_bit_clock(rbc),
        .serial_read_in(sri), .wr_byte(wr_byte), .wr_bits(wr_bits));

    // free-running bus clock
    initial begin
        pclk = 1'h0;
        forever #2.5 pclk = ~pclk;
    end

    // byte seen on the read stream starting at a given bit offset, lsb first
    function automatic logic [7:0] byte_at(input int o);
        for (int i = 0; i < 8; i++) byte_at[i] = rd_word[(o + i) % 16];
    endfunction : byte_at

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; waits on pready as long as it takes, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // a bit count that never arrives is counted as a mismatch
    task automatic wait_bits(input int n);
        for (int k = 0; k < 9000 && wr_bits < n; k++) @(posedge pclk);
        chk("serial bit count", 32'h1, 32'(wr_bits >= n));
    endtask : wait_bits

    // status polling; a byte takes 200 cycles so 300 reads is ample
    task automatic poll(input int b);
        int k;
        k = 0;
        do begin
            apb(1'h0, TBS_OFF_STATUS, 32'h0);
            k++;
        end while (q[b] !== 1'h1 && k < 300);
        chk("status wait", 32'h1, 32'(q[b]));
    endtask : poll

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    // hang guard, far beyond the expected run of a few thousand cycles
    initial begin
        repeat (60000) @(posedge pclk);
        num_errors++;
        summarize();
    end

    initial begin
        {presetn, psel, penable, pwrite, rbe, wclk_en, rclk_en} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rd_word = 16'h00F1;
        void'($urandom(2968));
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(1'h0, ra[i], 32'h0);
            chk("reset value", rv[i], q);
        end
        apb(1'h0, 8'h1C, 32'h0);
        chk("unmapped error", 32'h1, err);
        chk("unmapped data", 32'h0, q);
        $display("register test done");
        // write path: one good byte, a refill, then underrun with fill bytes
        d = 8'($urandom);
        d2 = 8'($urandom);
        d3 = 8'($urandom);
        f = 8'($urandom);
        apb(1'h1, TBS_OFF_FILL, {24'h0, f});
        apb(1'h1, TBS_OFF_CTRL, 32'h3);
        apb(1'h1, TBS_OFF_WDATA, {24'h0, d});
        wclk_en <= 1'h1;
        wait_bits(2);
        chk("write request", 32'h1, wreq);
        apb(1'h1, TBS_OFF_WDATA, {24'h0, d2});
        repeat (2) @(posedge pclk);
        chk("write request drop", 32'h0, wreq);
        wait_bits(8);
        chk("byte 1", d, wr_byte);
        wait_bits(16);
        chk("byte 2", d2, wr_byte);
        wait_bits(18);
        chk("underrun", 32'h1, wund);
        wait_bits(24);
        chk("fill 1", f, wr_byte);
        wait_bits(28);
        apb(1'h1, TBS_OFF_WDATA, {24'h0, d3});
        repeat (2) @(posedge pclk);
        chk("underrun clear", 32'h0, wund);
        wait_bits(32);
        chk("fill 2", f, wr_byte);
        wait_bits(40);
        chk("byte 3", d3, wr_byte);
        apb(1'h1, TBS_OFF_CTRL, 32'h1);
        wclk_en <= 1'h0;
        repeat (3) @(posedge pclk);
        chk("write enable off", 32'h0, twe);
        $display("write test done");
        // read path: the sync byte sits at odd bit offset 3 of the stream
        apb(1'h1, TBS_OFF_SYNC, 32'h1E);
        rclk_en <= 1'h1;
        rbe <= 1'h1;
        apb(1'h1, TBS_OFF_CTRL, 32'h0);
        poll(4);
        chk("sync found", 32'h1, sdet);
        poll(2);
        chk("sync with request", 32'h1, q[4]);
        apb(1'h0, TBS_OFF_RDATA, 32'h0);
        chk("sync byte", byte_at(3), q);
        chk("bus data", byte_at(3), rdo);
        chk("bus enable", 32'h1, roe);
        apb(1'h1, TBS_OFF_RCLR, 32'h0);
        repeat (2) @(posedge pclk);
        chk("read request clear", 32'h0, rreq);
        poll(2);
        apb(1'h0, TBS_OFF_RDATA, 32'h0);
        chk("framed byte", byte_at(11), q);
        chk("no sync", 32'(byte_at(11) == 8'h1E), sdet);
        apb(1'h1, TBS_OFF_RCLR, 32'h0);
        apb(1'h1, TBS_OFF_SYNC, {24'h0, byte_at(11)});
        poll(2);
        chk("old sync value", 32'h0, sdet);
        apb(1'h1, TBS_OFF_RCLR, 32'h0);
        poll(2);
        chk("new sync value", 32'h1, sdet);
        poll(3);
        chk("data lost", 32'h1, rlost);
        rbe <= 1'h0;
        repeat (6) @(posedge pclk);
        chk("bus released", 32'h0, roe);
        chk("bus released data", 32'h0, rdo);
        apb(1'h1, TBS_OFF_CTRL, 32'h1);
        rclk_en <= 1'h0;
        $display("read test done");
        summarize();
    end
endmodule : tbs_byte_serdes_sync_tb
